//--- rtl/mfs_supervisor.sv
// Fault supervision and power-mode control for a sensorless motor driver.
// Assumes estimator inputs on hclk; comparator and speed pins are asynchronous.
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "mfs_map.svh"
module mfs_supervisor
  import mfs_pkg::*;
#(
  parameter int NOMOTOR_CYC = `MFS_NOMOTOR_MS * (`MFS_CLK_HZ / 1000),
  parameter int RETRY_UNIT_CYC = `MFS_RETRY_UNIT_MS * (`MFS_CLK_HZ / 1000),
  parameter int DET_CYC = `MFS_DET_MS * (`MFS_CLK_HZ / 1000),
  parameter int SLEEP_ENT_CYC = `MFS_SLEEP_ENT_MS * (`MFS_CLK_HZ / 1000)
) (
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Estimators and drive state
  input  wire mfs_est_s    est,
  input  wire logic        motor_running,
  input  wire logic [7:0]  supply_level,
  input  wire logic        measure_rl_active,
  input  wire logic        measure_bemf_done,
  input  wire logic [7:0]  measure_bemf_value,
  // Position probe handshake
  input  wire logic        probe_pulse_start,
  input  wire logic        probe_current_reached,
  input  wire logic        probe_current_zero,
  output logic             probe_restart,
  output logic             startup_abort,
  output logic             startup_retry,
  // Asynchronous comparators and speed pin
  input  wire logic        temp_over_warn,
  input  wire logic        temp_below_warn_hys,
  input  wire logic        temp_over_shutdown,
  input  wire logic        temp_below_shutdown_hys,
  input  wire logic        speed_pin,
  // Speed command values
  input  wire logic [15:0] speed_frac,
  input  wire logic [14:0] digital_speed,
  input  wire logic [15:0] speed_freq_dhz,
  // Power and drive outputs
  output mfs_fet_e         fet_cmd,
  output logic             charge_pump_en,
  output logic             sleep_mode,
  output logic             standby_mode,
  output logic             fault_pin_n
);

  // Fraction of a full scale, truncated
  function automatic logic [15:0] pct_of(input int fs, input int p);
    pct_of = 16'((fs * p) / 100);
  endfunction : pct_of

  // Prescale terminal count for each probe clock step
  function automatic logic [9:0] step_div(input logic [1:0] s);
    unique case (s)
      2'h0: step_div = 10'(`MFS_CLK_HZ / `MFS_PROBE_F0_HZ - 1);
      2'h1: step_div = 10'(`MFS_CLK_HZ / `MFS_PROBE_F1_HZ - 1);
      2'h2: step_div = 10'(`MFS_CLK_HZ / `MFS_PROBE_F2_HZ - 1);
      2'h3: step_div = 10'(`MFS_CLK_HZ / `MFS_PROBE_F3_HZ - 1);
    endcase
  endfunction : step_div

  // Configuration registers
  mfs_cfg_s    cfg_q;
  mfs_lvl_s    lvl_q;
  mfs_sup_s    sup_q;
  // Bus pipeline
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        clear_q;
  logic [31:0] rd_mux;
  logic        acc;
  // Synchronisers: temp comparators and speed pin
  logic [4:0]  sy1_q, sy2_q, sy3_q, pin_q;
  // Status flags
  logic        bemf_lk_q, nm_lk_q, lock_hold_q, uv_q, ov_q;
  logic        mramp_q, mbemf_q, prise_q, pdecay_q, prate_q;
  logic        warn_pin_q, warn_flag_q, temp_flag_q, tsd_q, tsd_flag_q;
  // Lock and probe working state
  logic [22:0] nm_cnt_q;
  mfs_probe_e  pst_q;
  logic [1:0]  step_q;
  logic [9:0]  pre_q;
  logic [11:0] ptmr_q;
  logic        retry_busy_q;
  logic [13:0] unit_cnt_q;
  logic [7:0]  units_q;
  logic [22:0] det_cnt_q;
  // Registered outputs
  logic [31:0] hrdata_q;
  logic        hreadyout_q, hresp_q, restart_q, abort_q, retry_q;
  mfs_fet_e    fet_q;
  logic        pump_q, sleep_q, standby_q, fault_n_q;

  assign hrdata         = hrdata_q;
  assign hreadyout      = hreadyout_q;
  assign hresp          = hresp_q;
  assign probe_restart  = restart_q;
  assign startup_abort  = abort_q;
  assign startup_retry  = retry_q;
  assign fet_cmd        = fet_q;
  assign charge_pump_en = pump_q;
  assign sleep_mode     = sleep_q;
  assign standby_mode   = standby_q;
  assign fault_pin_n    = fault_n_q;

  // Comparator view: a change counts when stages two and three agree
  logic t_warn, t_warn_ok, t_tsd, t_tsd_ok, spd_hi;
  assign {t_warn, t_warn_ok, t_tsd, t_tsd_ok, spd_hi} = pin_q;

  // Three-stage synchroniser with agreement filter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy1_q <= 5'h00;
      sy2_q <= 5'h00;
      sy3_q <= 5'h00;
      pin_q <= 5'h00;
    end else if (ce) begin
      sy1_q <= {temp_over_warn, temp_below_warn_hys, temp_over_shutdown,
                temp_below_shutdown_hys, speed_pin};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      for (int i = 0; i < 5; i++) begin
        if (sy2_q[i] == sy3_q[i]) pin_q[i] <= sy3_q[i];
      end
    end
  end

  // Bus: address phase taken when selected and previous transfer done
  assign acc = hsel && htrans[1] && hready;

  // Read mux over the coined register map; unmapped reads zero
  always_comb begin
    unique case (haddr[7:0])
      `MFS_CFG_OFS:  rd_mux = cfg_q;
      `MFS_LVL_OFS:  rd_mux = lvl_q;
      `MFS_SUP_OFS:  rd_mux = sup_q;
      `MFS_STAT_OFS: rd_mux = {16'h0000, standby_q, sleep_q, tsd_flag_q, warn_flag_q,
                               temp_flag_q, tsd_q, prate_q, pdecay_q, prise_q, mbemf_q,
                               mramp_q, ov_q, uv_q, nm_lk_q, bemf_lk_q,
                               bemf_lk_q | nm_lk_q};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus pipeline: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else if (ce) begin
      wr_pend_q <= acc && hwrite;
      wr_addr_q <= haddr[7:0];
      if (acc && !hwrite) hrdata_q <= rd_mux;
    end
  end

  // Register writes in the data phase; reserved bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q   <= `MFS_CFG_RST;
      lvl_q   <= `MFS_LVL_RST;
      sup_q   <= `MFS_SUP_RST;
      clear_q <= 1'b0;
    end else if (ce) begin
      clear_q <= wr_pend_q && (wr_addr_q == `MFS_CLR_OFS) && hwdata[0];
      if (wr_pend_q && wr_addr_q == `MFS_CFG_OFS) cfg_q <= hwdata & `MFS_CFG_MASK;
      if (wr_pend_q && wr_addr_q == `MFS_LVL_OFS) lvl_q <= hwdata;
      if (wr_pend_q && wr_addr_q == `MFS_SUP_OFS) sup_q <= hwdata;
    end
  end

  // Lock conditions and response decode
  logic [11:0] bemf_diff;
  logic        cur_low, nm_cond, bemf_cond, lk_ign, lk_rep, lk_latch, lk_auto;
  logic        lock_raw, lock_new, retry_done;
  assign bemf_diff = (est.backemf_est > est.backemf_exp) ? est.backemf_est - est.backemf_exp
                                                         : est.backemf_exp - est.backemf_est;
  assign bemf_cond = motor_running && cfg_q.second_lock_enable
                     && (bemf_diff > lvl_q.backemf_error_threshold);
  assign cur_low   = (est.phase_current[11:0]  < lvl_q.missing_load_current_level)
                  || (est.phase_current[23:12] < lvl_q.missing_load_current_level)
                  || (est.phase_current[35:24] < lvl_q.missing_load_current_level);
  assign nm_cond   = cfg_q.third_lock_enable && (nm_cnt_q >= 23'(NOMOTOR_CYC));
  assign lk_ign    = cfg_q.lock_response_mode[3] && cfg_q.lock_response_mode[0];
  assign lk_rep    = cfg_q.lock_response_mode[3] && !cfg_q.lock_response_mode[0];
  assign lk_latch  = cfg_q.lock_response_mode[3:2] == 2'b00;
  assign lk_auto   = cfg_q.lock_response_mode[3:2] == 2'b01;
  assign lock_raw  = bemf_cond || nm_cond;
  assign lock_new  = lock_raw && !lk_ign;
  assign retry_done = retry_busy_q && (units_q == 8'h00) && (unit_cnt_q == 14'h0000);

  // Low-current dwell counter, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nm_cnt_q <= 23'h00_0000;
    end else if (ce) begin
      if (!(motor_running && cur_low)) nm_cnt_q <= 23'h00_0000;
      else if (nm_cnt_q < 23'(NOMOTOR_CYC)) nm_cnt_q <= nm_cnt_q + 23'h00_0001;
    end
  end

  // Lock flags: set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bemf_lk_q   <= 1'b0;
      nm_lk_q     <= 1'b0;
      lock_hold_q <= 1'b0;
    end else if (ce) begin
      if (bemf_cond && !lk_ign) bemf_lk_q <= 1'b1;
      else if (lk_auto ? retry_done : (clear_q && !bemf_cond)) bemf_lk_q <= 1'b0;
      if (nm_cond && !lk_ign) nm_lk_q <= 1'b1;
      else if (lk_auto ? retry_done : (clear_q && !nm_cond)) nm_lk_q <= 1'b0;
      if (lock_new && (lk_latch || lk_auto)) lock_hold_q <= 1'b1;
      else if (lk_auto ? retry_done : (clear_q && !lock_raw)) lock_hold_q <= 1'b0;
    end
  end

  // Supply window faults
  logic uv_cond, ov_cond, uv_ok, ov_ok;
  assign uv_cond = (sup_q.supply_low_level != 8'h00) && (supply_level < sup_q.supply_low_level);
  assign ov_cond = (sup_q.supply_high_level != 8'h00) && (supply_level > sup_q.supply_high_level);
  assign uv_ok   = supply_level > sup_q.supply_low_level + `MFS_UV_HYS;
  assign ov_ok   = supply_level < sup_q.supply_high_level - `MFS_OV_HYS;

  // Under- and overvoltage: latched or self-clearing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_q <= 1'b0;
      ov_q <= 1'b0;
    end else if (ce) begin
      if (uv_cond) uv_q <= 1'b1;
      else if (uv_ok && (cfg_q.supply_low_response || clear_q)) uv_q <= 1'b0;
      if (ov_cond) ov_q <= 1'b1;
      else if (ov_ok && (cfg_q.supply_high_response || clear_q)) ov_q <= 1'b0;
    end
  end

  // Probe timing and failure detection
  logic probe_on, tick, ovf, rise_fail, decay_fail, rate_fail, ipd_fault;
  assign probe_on   = (cfg_q.startup_method == `MFS_STARTUP_PROBE) || measure_rl_active;
  assign tick       = pre_q == step_div(step_q);
  assign ovf        = tick && (ptmr_q == 12'hFFF);
  assign rise_fail  = (pst_q == PR_RISE) && !probe_current_reached && ovf && (step_q == 2'h3);
  assign decay_fail = (pst_q == PR_DECAY) && !probe_current_zero && ovf && (step_q == 2'h3);
  assign rate_fail  = (pst_q == PR_DECAY) && !probe_current_zero && probe_pulse_start;
  assign ipd_fault  = (cfg_q.probe_overflow_error_enable && !measure_rl_active
                       && (rise_fail || decay_fail))
                   || (cfg_q.probe_rate_error_enable && rate_fail);

  // Probe sequencer: retries at each slower clock after overflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pst_q     <= PR_IDLE;
      step_q    <= 2'h0;
      pre_q     <= 10'h000;
      ptmr_q    <= 12'h000;
      restart_q <= 1'b0;
    end else if (ce) begin
      restart_q <= 1'b0;
      unique case (pst_q)
        PR_IDLE: begin
          step_q <= 2'h0;
          pre_q  <= 10'h000;
          ptmr_q <= 12'h000;
          if (probe_pulse_start && probe_on && !retry_busy_q) pst_q <= PR_RISE;
        end
        PR_RISE, PR_DECAY: begin
          if (ipd_fault) begin
            pst_q <= PR_IDLE;
          end else if (pst_q == PR_RISE && probe_current_reached) begin
            pst_q  <= PR_DECAY;
            step_q <= 2'h0;
            pre_q  <= 10'h000;
            ptmr_q <= 12'h000;
          end else if (pst_q == PR_DECAY && probe_current_zero) begin
            pst_q <= PR_IDLE;
          end else if (ovf) begin
            if (step_q == 2'h3) begin
              pst_q <= PR_IDLE;
            end else begin
              step_q    <= step_q + 2'h1;
              pre_q     <= 10'h000;
              ptmr_q    <= 12'h000;
              restart_q <= 1'b1;
            end
          end else begin
            pre_q <= tick ? 10'h000 : pre_q + 10'h001;
            if (tick) ptmr_q <= ptmr_q + 12'h001;
          end
        end
        default: pst_q <= PR_IDLE;
      endcase
    end
  end

  // Probe and measurement error flags, cleared by clear fault
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mramp_q  <= 1'b0;
      mbemf_q  <= 1'b0;
      prise_q  <= 1'b0;
      pdecay_q <= 1'b0;
      prate_q  <= 1'b0;
    end else if (ce) begin
      if (rise_fail && measure_rl_active) mramp_q <= 1'b1;
      else if (clear_q) mramp_q <= 1'b0;
      if (measure_bemf_done && measure_bemf_value < lvl_q.stationary_level) mbemf_q <= 1'b1;
      else if (clear_q) mbemf_q <= 1'b0;
      if (rise_fail && !measure_rl_active && cfg_q.probe_overflow_error_enable) prise_q <= 1'b1;
      else if (clear_q) prise_q <= 1'b0;
      if (decay_fail && !measure_rl_active && cfg_q.probe_overflow_error_enable) pdecay_q <= 1'b1;
      else if (clear_q) pdecay_q <= 1'b0;
      if (rate_fail && cfg_q.probe_rate_error_enable) prate_q <= 1'b1;
      else if (clear_q) prate_q <= 1'b0;
    end
  end

  // Retry wait shared by probe faults and self-recovering locks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      retry_busy_q <= 1'b0;
      unit_cnt_q   <= 14'h0000;
      units_q      <= 8'h00;
      abort_q      <= 1'b0;
      retry_q      <= 1'b0;
    end else if (ce) begin
      abort_q <= ipd_fault;
      retry_q <= retry_done;
      if (!retry_busy_q && (ipd_fault || (lock_new && lk_auto))) begin
        retry_busy_q <= 1'b1;
        units_q      <= sup_q.lock_retry_time;
        unit_cnt_q   <= 14'(RETRY_UNIT_CYC - 1);
      end else if (retry_done) begin
        retry_busy_q <= 1'b0;
      end else if (retry_busy_q) begin
        if (unit_cnt_q != 14'h0000) begin
          unit_cnt_q <= unit_cnt_q - 14'h0001;
        end else begin
          unit_cnt_q <= 14'(RETRY_UNIT_CYC - 1);
          units_q    <= units_q - 8'h01;
        end
      end
    end
  end

  // Thermal warning and shutdown
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warn_pin_q  <= 1'b0;
      warn_flag_q <= 1'b0;
      temp_flag_q <= 1'b0;
      tsd_q       <= 1'b0;
      tsd_flag_q  <= 1'b0;
    end else if (ce) begin
      if (t_warn && cfg_q.heat_warning_report_enable) warn_pin_q <= 1'b1;
      else if (t_warn_ok) warn_pin_q <= 1'b0;
      if (t_warn && cfg_q.heat_warning_report_enable) warn_flag_q <= 1'b1;
      else if (clear_q && t_warn_ok) warn_flag_q <= 1'b0;
      // Shutdown has no enable: it cannot be switched off
      if (t_tsd) tsd_q <= 1'b1;
      else if (t_tsd_ok) tsd_q <= 1'b0;
      if (t_tsd) tsd_flag_q <= 1'b1;
      else if (clear_q) tsd_flag_q <= 1'b0;
      if (t_tsd || (t_warn && cfg_q.heat_warning_report_enable)) temp_flag_q <= 1'b1;
      else if (clear_q && !tsd_q && !warn_pin_q) temp_flag_q <= 1'b0;
    end
  end

  // Standby thresholds per speed input mode
  logic [15:0] hys_thr, ser_thr;
  logic        sb_low, sb_high, sl_cond, wake_cond;
  logic [22:0] sl_need;
  assign hys_thr = (cfg_q.ref_profile != 2'b00) ? 16'h0000 :
                   pct_of(`MFS_ANA_FS, (sup_q.duty_hysteresis > 8'(`MFS_SB_ENTER_PCT))
                          ? int'(sup_q.duty_hysteresis) : `MFS_SB_ENTER_PCT);
  assign ser_thr = (cfg_q.ref_profile != 2'b00) ? 16'h0000 :
                   pct_of(`MFS_SER_FS, (sup_q.duty_hysteresis > 8'(`MFS_SB_ENTER_PCT))
                          ? int'(sup_q.duty_hysteresis) : `MFS_SB_ENTER_PCT);

  // Entry and exit compares, plus sleep dwell conditions
  always_comb begin
    sl_need = 23'(DET_CYC);
    unique case (cfg_q.speed_mode)
      2'b00: begin
        sb_low    = speed_frac < pct_of(`MFS_ANA_FS, `MFS_SB_ENTER_PCT);
        sb_high   = speed_frac > pct_of(`MFS_ANA_FS, `MFS_SB_EXIT_PCT);
        sl_cond   = sb_low;
        wake_cond = sb_high;
      end
      2'b01: begin
        sb_low    = speed_frac < hys_thr;
        sb_high   = speed_frac > hys_thr;
        sl_cond   = !spd_hi;
        wake_cond = spd_hi;
      end
      2'b10: begin
        sb_low    = {1'b0, digital_speed} < ser_thr;
        sb_high   = {1'b0, digital_speed} > ser_thr;
        sl_cond   = (digital_speed == 15'h0000) && !spd_hi;
        wake_cond = spd_hi;
        if (!sleep_q) sl_need = 23'(SLEEP_ENT_CYC);
      end
      2'b11: begin
        sb_low    = speed_freq_dhz < `MFS_FREQ_SB_DHZ;
        sb_high   = !sb_low;
        sl_cond   = !spd_hi;
        wake_cond = spd_hi;
      end
    endcase
  end

  // Sleep and standby state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_q   <= 1'b0;
      standby_q <= 1'b0;
      det_cnt_q <= 23'h00_0000;
    end else if (ce) begin
      if (!cfg_q.idle_state_select || !(sleep_q ? wake_cond : sl_cond)) begin
        det_cnt_q <= 23'h00_0000;
      end else if (det_cnt_q >= sl_need - 23'h00_0001) begin
        det_cnt_q <= 23'h00_0000;
        sleep_q   <= !sleep_q;
      end else begin
        det_cnt_q <= det_cnt_q + 23'h00_0001;
      end
      if (cfg_q.idle_state_select) standby_q <= 1'b0;
      else if (sb_low) standby_q <= 1'b1;
      else if (sb_high) standby_q <= 1'b0;
      if (!cfg_q.idle_state_select) sleep_q <= 1'b0;
    end
  end

  // Drive outputs: hi-Z has priority over lock-held states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fet_q     <= FET_HIZ;
      pump_q    <= 1'b0;
      fault_n_q <= 1'b1;
    end else if (ce) begin
      pump_q <= !(tsd_q || sleep_q);
      if (sleep_q || tsd_q || uv_q || ov_q || abort_q || retry_busy_q && !lk_auto)
        fet_q <= FET_HIZ;
      else if (lock_hold_q && cfg_q.lock_response_mode[1:0] == 2'b10) fet_q <= FET_HIGH_ON;
      else if (lock_hold_q && cfg_q.lock_response_mode[1:0] == 2'b11) fet_q <= FET_LOW_ON;
      else if (lock_hold_q) fet_q <= FET_HIZ;
      else fet_q <= FET_RUN;
      fault_n_q <= !(bemf_lk_q || nm_lk_q || uv_q || ov_q || mramp_q || mbemf_q || prise_q
                     || pdecay_q || prate_q || warn_pin_q || tsd_q);
    end
  end

endmodule : mfs_supervisor

//--- include/mfs_map.svh
// Constants of the motor fault supervisor: offsets, fields, resets, timing.
// Assumes a 10 MHz hclk; the including file supplies the module around it.
// Functional notes
// - Back-EMF mismatch lock, gated by second enable
// - Phase current low 500 ms: missing load
// - Undervoltage: latch or auto restart above +0.5V
// - Overvoltage: latch or auto restart below -1V
// - Measurement ramp overflow reports measure ramp error
// - Measured back-EMF below stationary level errors
// - Probe rise timed, four clocks, then error
// - Probe decay timed, four clocks, then error
// - Probe overflow counts only with overflow enable set
// - New probe before decay gives rate error
// - Probe fault aborts, hi-Z, retries later
// - Heat warning: pin low, flags, nothing else
// - Warning pin releases at hysteresis; flag needs clear
// - Heat shutdown: FETs, pump off; not disableable
// - Shutdown flag stays until clear fault
// - Idle select one: sleep disables everything
// - Idle select zero: standby keeps supplies alive
// - Analog 1%/5% standby, frequency below 3 Hz
// - Duty and serial thresholds from hysteresis
// - Sleep entry and wake after detection time; serial-mode entry uses sleep entry time
// - Latched fault cleared by clear bit write
// - Lock response mode selects lock action
`ifndef MFS_MAP_SVH
`define MFS_MAP_SVH
`define MFS_CFG_OFS      8'h00
`define MFS_LVL_OFS      8'h04
`define MFS_SUP_OFS      8'h08
`define MFS_CLR_OFS      8'h0C
`define MFS_STAT_OFS     8'h10
`define MFS_CFG_MASK     32'h0003_FFFF
`define MFS_CFG_RST      32'h0000_0C00
`define MFS_LVL_RST      32'h0000_0000
`define MFS_SUP_RST      32'h0000_0A01
`define MFS_CLK_HZ       10000000
`define MFS_NOMOTOR_MS   500
`define MFS_RETRY_UNIT_MS 1
`define MFS_DET_MS       1
`define MFS_SLEEP_ENT_MS 1
`define MFS_UV_HYS       8'h01
`define MFS_OV_HYS       8'h02
`define MFS_ANA_FS       65535
`define MFS_SER_FS       32767
`define MFS_SB_ENTER_PCT 1
`define MFS_SB_EXIT_PCT  5
`define MFS_FREQ_SB_DHZ  16'h001E
`define MFS_PROBE_F0_HZ  10000000
`define MFS_PROBE_F1_HZ  1000000
`define MFS_PROBE_F2_HZ  100000
`define MFS_PROBE_F3_HZ  10000
`define MFS_STARTUP_PROBE 2'h2
`endif

//--- include/mfs_pkg.sv
// Types of the motor fault supervisor: register layouts and states.
// Assumes the map header carries all numeric constants.
package mfs_pkg;
  typedef enum logic [1:0] {FET_RUN, FET_HIZ, FET_HIGH_ON, FET_LOW_ON} mfs_fet_e;
  typedef enum logic [1:0] {PR_IDLE, PR_RISE, PR_DECAY} mfs_probe_e;
  typedef struct packed {
    logic [13:0] rsvd;
    logic [3:0]  lock_response_mode;
    logic        second_lock_enable;
    logic        third_lock_enable;
    logic        supply_low_response;
    logic        supply_high_response;
    logic        probe_overflow_error_enable;
    logic        probe_rate_error_enable;
    logic        heat_warning_report_enable;
    logic        idle_state_select;
    logic [1:0]  startup_method;
    logic [1:0]  speed_mode;
    logic [1:0]  ref_profile;
  } mfs_cfg_s;
  typedef struct packed {
    logic [11:0] backemf_error_threshold;
    logic [11:0] missing_load_current_level;
    logic [7:0]  stationary_level;
  } mfs_lvl_s;
  typedef struct packed {
    logic [7:0] supply_low_level;
    logic [7:0] supply_high_level;
    logic [7:0] lock_retry_time;
    logic [7:0] duty_hysteresis;
  } mfs_sup_s;
  typedef struct packed {
    logic [11:0] backemf_est;
    logic [11:0] backemf_exp;
    logic [35:0] phase_current;
  } mfs_est_s;
endpackage : mfs_pkg

//--- test/mfs_supervisor_sva.sv
// Port checker for the supervisor: thermal, sleep, probe and bus timing.
// Assumes a bind onto the supervisor; one clock, async active-low reset.
`timescale 1ns/1ps
module mfs_sup_chk
  import mfs_pkg::*;
(
  // Clock and reset
  input wire logic     hclk,
  input wire logic     hresetn,
  // Watched ports
  input wire logic     hreadyout,
  input wire logic     hresp,
  input wire logic     temp_over_shutdown,
  input wire logic     charge_pump_en,
  input wire mfs_fet_e fet_cmd,
  input wire logic     fault_pin_n,
  input wire logic     sleep_mode,
  input wire logic     probe_restart,
  input wire logic     startup_abort,
  input wire logic     startup_retry
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Long enough for the synchroniser and the output register
  sequence hot_s; temp_over_shutdown [*8]; endsequence
  chk_hot_pump: assert property (hot_s |-> !charge_pump_en && fet_cmd == FET_HIZ)
    else $error("FETs or pump on in shutdown");
  chk_hot_pin: assert property (hot_s |-> !fault_pin_n)
    else $error("fault pin high in shutdown");
  chk_run_pump: assert property (fet_cmd == FET_RUN |-> charge_pump_en)
    else $error("FETs run without pump");
  chk_sleep_off: assert property (sleep_mode |=> !charge_pump_en && fet_cmd != FET_RUN)
    else $error("supply alive in sleep");
  chk_abort_hiz: assert property (startup_abort |-> ##[0:1] fet_cmd == FET_HIZ)
    else $error("abort without hi-Z");
  chk_retry_wait: assert property (startup_abort |=> !startup_retry [*8])
    else $error("retry too soon");
  chk_step_gap: assert property (probe_restart |=> !probe_restart [*8])
    else $error("probe steps too close");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error");
endmodule : mfs_sup_chk
bind mfs_supervisor mfs_sup_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp,
  .temp_over_shutdown, .charge_pump_en, .fet_cmd, .fault_pin_n, .sleep_mode,
  .probe_restart, .startup_abort, .startup_retry);

//--- test/mfs_speed_src.sv
// Speed command source: analog level and speed pin from one command.
// Assumes the bench changes the command just after a clock edge.
`timescale 1ns/1ps
module mfs_speed_src (
  // Clock and command
  input  wire logic        hclk,
  input  wire logic [15:0] cmd,
  // Speed outputs
  output logic      [15:0] speed_frac,
  output logic             speed_pin
);
  // Pin low only for a zero command, so sleep entry outside analog mode needs a stop
  always_ff @(posedge hclk) begin
    speed_frac <= cmd;
    speed_pin  <= |cmd;
  end
endmodule : mfs_speed_src

//--- test/test_motor_fault_supervisor.sv
// Bench: register tasks over the bus, fault and power-mode scenarios.
// Assumes the supervisor, its package and the speed source model.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module test_motor_fault_supervisor import mfs_pkg::*;;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pst = 0, prc = 0, pcz = 1;
  logic tow = 0, tbw = 1, tos = 0, tbs = 1, mr = 0, mra = 0, mbd = 0, ce = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic [7:0] sup = 8'h40, mbv = 0;
  logic [15:0] cmd = 16'hFFFF, fdz = 16'h0064, frac;
  logic hreadyout, hresp, pin, cpe, slp, stb, fpn;
  mfs_fet_e fet;
  mfs_est_s est = '0;
  int n_fail = 0, checks_done = 0;
  always #50 hclk = ~hclk;
  mfs_speed_src u_src (.hclk(hclk), .cmd(cmd), .speed_frac(frac), .speed_pin(pin));
  mfs_supervisor #(.NOMOTOR_CYC(50), .RETRY_UNIT_CYC(10), .DET_CYC(20), .SLEEP_ENT_CYC(20))
  u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .est(est), .motor_running(mr),
    .supply_level(sup), .measure_rl_active(mra), .measure_bemf_done(mbd),
    .measure_bemf_value(mbv), .probe_pulse_start(pst), .probe_current_reached(prc),
    .probe_current_zero(pcz), .probe_restart(), .startup_abort(), .startup_retry(),
    .temp_over_warn(tow), .temp_below_warn_hys(tbw), .temp_over_shutdown(tos),
    .temp_below_shutdown_hys(tbs), .speed_pin(pin), .speed_frac(frac),
    .digital_speed(cmd[14:0]), .speed_freq_dhz(fdz), .fet_cmd(fet), .charge_pump_en(cpe),
    .sleep_mode(slp), .standby_mode(stb), .fault_pin_n(fpn));
  // One single-word transfer; read data lands in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wt(input int n); repeat (n) @(posedge hclk); endtask : wt
  task automatic end_sim;
    $display("Checks %0d, errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // Watchdog, far beyond the tests
  initial begin #2_000_000; n_fail++; end_sim; end
  initial begin
    wt(16); hresetn <= 1'b1; wt(1);
    bus(0, 8'h00, 0); `CHK(r, 32'h0000_0C00)
    bus(0, 8'h08, 0); `CHK(r, 32'h0000_0A01)
    bus(0, 8'h14, 0); `CHK(r, 32'h0000_0000)
    // Thermal shutdown, recovery, then the sticky flag
    tos <= 1; tbs <= 0; wt(10); bus(0, 8'h10, 0); `CHK({fpn, r[13:10]}, 5'b01011)
    tos <= 0; tbs <= 1; wt(10); bus(0, 8'h10, 0); `CHK({fpn, r[13:10]}, 5'b11010)
    bus(1, 8'h0C, 1); wt(2); bus(0, 8'h10, 0); `CHK(r[13:10], 4'b0000)
    // Undervoltage self-clearing: hysteresis boundary
    bus(1, 8'h08, 32'h2060_0A01); sup <= 8'h10; wt(3); `CHK(fet, FET_HIZ)
    sup <= 8'h21; wt(3); bus(0, 8'h10, 0); `CHK(r[3], 1'b1)
    sup <= 8'h22; wt(3); bus(0, 8'h10, 0); `CHK(r[3], 1'b0)
    // Latched undervoltage needs a clear
    bus(1, 8'h00, 0); sup <= 8'h10; wt(3); sup <= 8'h40; wt(3);
    bus(0, 8'h10, 0); `CHK({r[3], fet}, {1'b1, FET_HIZ})
    bus(1, 8'h0C, 1); wt(3); bus(0, 8'h10, 0); `CHK({r[3], fet}, {1'b0, FET_RUN})
    // Sleep entry and wake, then standby hysteresis
    bus(1, 8'h00, 32'h0000_0040); cmd <= 0; wt(40); `CHK({slp, cpe}, 2'b10)
    cmd <= 16'hFFFF; wt(40); `CHK(slp, 1'b0)
    bus(1, 8'h00, 0); cmd <= 16'd600; wt(10); `CHK({stb, cpe}, 2'b11)
    cmd <= 16'd3200; wt(10); `CHK(stb, 1'b1)
    cmd <= 16'd3300; wt(10); `CHK(stb, 1'b0)
    // Second probe pulse during decay
    bus(1, 8'h00, 32'h0000_0120); pst <= 1; wt(1); pst <= 0; prc <= 1; pcz <= 0; wt(5);
    pst <= 1; wt(1); pst <= 0; wt(3); bus(0, 8'h10, 0); `CHK({r[9], fet}, {1'b1, FET_HIZ})
    wt(150);
    bus(1, 8'h00, 32'h0000_2000); est.backemf_est <= 12'h010; mr <= 1; wt(3);
    bus(0, 8'h10, 0); `CHK({r[1:0], fpn, fet}, {3'b110, FET_HIZ})
    est <= '0; ce <= 0; bus(1, 8'h0C, 1); ce <= 1; bus(0, 8'h10, 0);
    `CHK(r[1], 1'b1)
    end_sim;
  end
endmodule : test_motor_fault_supervisor
